/* logic/crcrm_regmap.v */
// register map of both channels with crc command decoding
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
//
// Operation
// - crc field 00 causes no crc action
// - crc field 01 initialises the receive crc checker
// - disabling the receiver initialises the receive crc checker
// - in sdlc mode the receive checker resets automatically
// - crc field 10 initialises the transmit crc generator
// - channel reset leaves the transmit crc generator alone
// - auto end_of_message reset option resets the generator by itself
// - field 11 resets the latch; underrun then appends crc
// - sdlc with abort on underrun sends abort and flag instead
// - latch is set when crc transmission begins
// - latch reset is ignored while the transmitter is disabled
// - that ignored reset raises ext status with underrun bit clear
// - master interrupt and vector registers shared by both channels
// - vector readback modified on channel b, raw on channel a
// - pending bits register readable through channel a only
// - extended read bit exposes five write registers for readback
// - frame count registers visible only with frame fifo in sdlc
// - absent reserved bits read zero, present ones read back
// - each channel holds 10 control, 2 sync and 2 baud registers
// - command code 010 re-enables latched external status
module crcrm_regmap #(
   parameter ADDR_W = 5
) (
   input  wire              clock,
   input  wire              arst_n,
   input  wire [ADDR_W-1:0] addr,
   input  wire [7:0]        wrData,
   input  wire              wrStb,
   input  wire              rdStb,
   output reg  [7:0]        rdData_r,
   input  wire [1:0]        txUnderrun,
   input  wire [1:0]        crcTxStart,
   input  wire [1:0]        txFrameEnd,
   input  wire [1:0]        rxFrameEnd,
   input  wire [1:0]        extEvent,
   input  wire [15:0]       frameCountA,
   input  wire [15:0]       frameCountB,
   output reg  [1:0]        rxCrcInit_r,
   output reg  [1:0]        txCrcInit_r,
   output reg  [1:0]        appendCrc_r,
   output reg  [1:0]        sendAbort_r,
   output reg  [1:0]        eomLatch_r,
   output reg  [1:0]        extPending_r
);
`include "crcrm_consts.vh"

   // ==========================================================
   // write register storage
   // index {chanA, regNum}; 2 and 9 are held once for both channels
   reg  [7:0] wregs [0:31];
   reg  [7:0] vector_r;
   reg  [7:0] masterIntr_r;
   reg  [7:0] extFeat_r [0:1];
   integer    i;

   wire       chanA   = addr[`CRCRM_CHAN_A_BIT];
   wire [3:0] regNum  = addr[3:0];
   wire [4:0] wIdx    = {chanA, regNum};
   // prime register is reached at 7 while the enable bit is set
   wire       primeSel = wregs[{chanA, `CRCRM_EXTEN_REG}][`CRCRM_PRIME_BIT];
   wire       hwReset  = wrStb && regNum == `CRCRM_MIR_REG &&
                         wrData[7:6] == `CRCRM_RST_HW;
   wire [1:0] chanRst;

   assign chanRst[1] = hwReset || (wrStb && regNum == `CRCRM_MIR_REG &&
                                   wrData[7:6] == `CRCRM_RST_CHA);
   assign chanRst[0] = hwReset || (wrStb && regNum == `CRCRM_MIR_REG &&
                                   wrData[7:6] == `CRCRM_RST_CHB);

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (i = 0; i < 32; i = i + 1)
            wregs[i] <= 8'h00;
         vector_r      <= 8'h00;
         masterIntr_r  <= 8'h00;
         extFeat_r[0]  <= 8'h00;
         extFeat_r[1]  <= 8'h00;
      end else begin
         // channel reset clears that channel's bank, disabling rx and tx
         for (i = 0; i < 16; i = i + 1) begin
            if (chanRst[0])
               wregs[i] <= 8'h00;
            if (chanRst[1])
               wregs[i + 16] <= 8'h00;
         end
         if (hwReset)
            vector_r <= 8'h00;
         if (wrStb) begin
            case (regNum)
               `CRCRM_VEC_REG: vector_r <= wrData;
               `CRCRM_MIR_REG: masterIntr_r <= {2'h0, wrData[5:0]};
               `CRCRM_CMD_REG: ;
               `CRCRM_EXTF_REG: begin
                  if (primeSel)
                     extFeat_r[chanA] <= wrData;
                  else
                     wregs[wIdx] <= wrData;
               end
               default: wregs[wIdx] <= wrData;
            endcase
         end
      end
   end

   // ==========================================================
   // per-channel control derived from the write registers
   wire [1:0] rxEn;
   wire [1:0] txEn;
   wire [1:0] sdlc;
   wire [1:0] abortUr;
   wire [1:0] autoEom;
   wire [1:0] cmdWr;
   wire [1:0] rxI;
   wire [1:0] txI;
   wire [1:0] apI;
   wire [1:0] abI;
   wire [1:0] eomI;
   wire [1:0] eomStat;
   wire [1:0] extI;
   wire       extRstCmd = wrData[5:3] == `CRCRM_CMD_EXTRST;

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_chan
         assign rxEn[c]    = wregs[{c[0], `CRCRM_RXPAR_REG}][`CRCRM_RXEN_BIT];
         assign txEn[c]    = wregs[{c[0], `CRCRM_TXPAR_REG}][`CRCRM_TXEN_BIT];
         assign sdlc[c]    = (wregs[{c[0], `CRCRM_MODE_REG}] &
                              `CRCRM_SDLC_MASK) == `CRCRM_SDLC_MODE;
         assign abortUr[c] =
                wregs[{c[0], `CRCRM_MISC_REG}][`CRCRM_ABORT_UR_BIT];
         assign autoEom[c] = extFeat_r[c][`CRCRM_AUTOEOM_BIT];
         assign cmdWr[c]   = wrStb && regNum == `CRCRM_CMD_REG &&
                             chanA == c[0];

         crcrm_chan_ctl u_ctl (
            .clock           (clock),
            .arst_n          (arst_n),
            .chanReset       (chanRst[c]),
            .cmdWr           (cmdWr[c]),
            .crcCode         (wrData[7:6]),
            .extResetCmd     (extRstCmd),
            .rxEnabled       (rxEn[c]),
            .txEnabled       (txEn[c]),
            .sdlcMode        (sdlc[c]),
            .abortOnUnderrun (abortUr[c]),
            .autoEomReset    (autoEom[c]),
            .txUnderrun      (txUnderrun[c]),
            .crcTxStart      (crcTxStart[c]),
            .txFrameEnd      (txFrameEnd[c]),
            .rxFrameEnd      (rxFrameEnd[c]),
            .extEvent        (extEvent[c]),
            .rxCrcInit_r     (rxI[c]),
            .txCrcInit_r     (txI[c]),
            .appendCrc_r     (apI[c]),
            .sendAbort_r     (abI[c]),
            .eomLatch_r      (eomI[c]),
            .eomStatus_r     (eomStat[c]),
            .extPending_r    (extI[c])
         );
      end
   endgenerate

   // outputs pass through one more flop so every top output is registered
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rxCrcInit_r  <= 2'h0;
         txCrcInit_r  <= 2'h0;
         appendCrc_r  <= 2'h0;
         sendAbort_r  <= 2'h0;
         eomLatch_r   <= 2'h3;
         extPending_r <= 2'h0;
      end else begin
         rxCrcInit_r  <= rxI;
         txCrcInit_r  <= txI;
         appendCrc_r  <= apI;
         sendAbort_r  <= abI;
         eomLatch_r   <= eomI;
         extPending_r <= extI;
      end
   end

   // ==========================================================
   // read path
   reg  [7:0] rdNxt;
   reg  [2:0] visCode;
   wire       chanSel   = chanA;
   wire       extRead   = extFeat_r[chanSel][`CRCRM_EXTRD_BIT];
   wire       fifoOn    = wregs[{chanSel, `CRCRM_EXTEN_REG}]
                                 [`CRCRM_FIFOEN_BIT] && sdlc[chanSel];
   wire [7:0] pending;

   // only the external/status pending bits live here; the rest read zero
   assign pending = {4'h0, extI[1], 2'h0, extI[0]};

   always @* begin
      if (extI[1])
         visCode = `CRCRM_VIS_EXTA;
      else if (extI[0])
         visCode = `CRCRM_VIS_EXTB;
      else
         visCode = `CRCRM_VIS_NONE;
   end

   always @* begin
      rdNxt = 8'h00;
      case (regNum)
         `CRCRM_RD_STATUS:
            rdNxt[`CRCRM_EOM_STAT_BIT] = eomStat[chanSel];
         `CRCRM_RD_VECTOR: begin
            if (chanA)
               rdNxt = vector_r;
            else
               rdNxt = {vector_r[7:4], visCode, vector_r[0]};
         end
         `CRCRM_RD_PENDING:
            if (chanA)
               rdNxt = pending;
         `CRCRM_RD_MODE:
            if (extRead)
               rdNxt = wregs[{chanSel, `CRCRM_MODE_REG}];
         `CRCRM_RD_TXPAR:
            if (extRead)
               rdNxt = wregs[{chanSel, `CRCRM_TXPAR_REG}];
         `CRCRM_RD_RXPAR:
            if (extRead)
               rdNxt = wregs[{chanSel, `CRCRM_RXPAR_REG}];
         `CRCRM_RD_MISC:
            if (extRead)
               rdNxt = wregs[{chanSel, `CRCRM_MISC_REG}];
         `CRCRM_RD_EXTF:
            if (extRead)
               rdNxt = extFeat_r[chanSel];
         `CRCRM_RD_FCLO:
            if (fifoOn)
               rdNxt = chanA ? frameCountA[7:0] : frameCountB[7:0];
         `CRCRM_RD_FCHI:
            if (fifoOn)
               rdNxt = chanA ? frameCountA[15:8] : frameCountB[15:8];
         `CRCRM_RD_BAUDLO:
            rdNxt = wregs[{chanSel, 4'hc}];
         `CRCRM_RD_BAUDHI:
            rdNxt = wregs[{chanSel, 4'hd}];
         default:
            rdNxt = 8'h00;
      endcase
   end

   // read data stand one cycle, zero otherwise
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         rdData_r <= 8'h00;
      else if (rdStb)
         rdData_r <= rdNxt;
      else
         rdData_r <= 8'h00;
   end

endmodule // crcrm_regmap

/* logic/crcrm_consts.vh */
// constants for the crc command and register map block
`ifndef CRCRM_CONSTS_VH
`define CRCRM_CONSTS_VH

// ==========================================================
// register numbers inside one channel (address bits 3..0)
`define CRCRM_CMD_REG       4'h0
`define CRCRM_VEC_REG       4'h2
`define CRCRM_RXPAR_REG     4'h3
`define CRCRM_MODE_REG      4'h4
`define CRCRM_TXPAR_REG     4'h5
`define CRCRM_EXTF_REG      4'h7
`define CRCRM_MIR_REG       4'h9
`define CRCRM_MISC_REG      4'ha
`define CRCRM_EXTEN_REG     4'hf
// read numbers
`define CRCRM_RD_STATUS     4'h0
`define CRCRM_RD_VECTOR     4'h2
`define CRCRM_RD_PENDING    4'h3
`define CRCRM_RD_MODE       4'h4
`define CRCRM_RD_TXPAR      4'h5
`define CRCRM_RD_FCLO       4'h6
`define CRCRM_RD_FCHI       4'h7
`define CRCRM_RD_RXPAR      4'h9
`define CRCRM_RD_MISC       4'hb
`define CRCRM_RD_BAUDLO     4'hc
`define CRCRM_RD_BAUDHI     4'hd
`define CRCRM_RD_EXTF       4'he
// address bit that selects channel a
`define CRCRM_CHAN_A_BIT    4

// ==========================================================
// command register fields
`define CRCRM_CRC_NULL      2'h0
`define CRCRM_CRC_RXRST     2'h1
`define CRCRM_CRC_TXRST     2'h2
`define CRCRM_CRC_EOMRST    2'h3
`define CRCRM_CMD_EXTRST    3'h2

// ==========================================================
// bit positions
`define CRCRM_RXEN_BIT      0
`define CRCRM_TXEN_BIT      3
`define CRCRM_ABORT_UR_BIT  2
`define CRCRM_AUTOEOM_BIT   1
`define CRCRM_EXTRD_BIT     6
`define CRCRM_PRIME_BIT     0
`define CRCRM_FIFOEN_BIT    2
`define CRCRM_EOM_STAT_BIT  6
`define CRCRM_SDLC_MODE     8'h20
`define CRCRM_SDLC_MASK     8'h30
// master interrupt register reset commands (bits 7..6)
`define CRCRM_RST_CHB       2'h1
`define CRCRM_RST_CHA       2'h2
`define CRCRM_RST_HW        2'h3

// ==========================================================
// vector status codes for bits 3..1
`define CRCRM_VIS_EXTB      3'h1
`define CRCRM_VIS_NONE      3'h3
`define CRCRM_VIS_EXTA      3'h5
// pending register bit positions
`define CRCRM_PEND_EXTB     0
`define CRCRM_PEND_EXTA     3

`endif

/* logic/crcrm_chan_ctl.v */
// per-channel crc reset, underrun/end_of_message latch and ext status
`timescale 1ns/10ps
module crcrm_chan_ctl (
   input  wire       clock,
   input  wire       arst_n,
   input  wire       chanReset,
   input  wire       cmdWr,
   input  wire [1:0] crcCode,
   input  wire       extResetCmd,
   input  wire       rxEnabled,
   input  wire       txEnabled,
   input  wire       sdlcMode,
   input  wire       abortOnUnderrun,
   input  wire       autoEomReset,
   input  wire       txUnderrun,
   input  wire       crcTxStart,
   input  wire       txFrameEnd,
   input  wire       rxFrameEnd,
   input  wire       extEvent,
   output reg        rxCrcInit_r,
   output reg        txCrcInit_r,
   output reg        appendCrc_r,
   output reg        sendAbort_r,
   output reg        eomLatch_r,
   output reg        eomStatus_r,
   output reg        extPending_r
);
`include "crcrm_consts.vh"

   reg  rxEnPrev_r;
   wire eomRstCmd = cmdWr && (crcCode == `CRCRM_CRC_EOMRST);
   // latch reset while the transmitter is off raises ext status instead
   wire eomIdleEvt = eomRstCmd && !txEnabled &&
                     (!extPending_r || extResetCmd);
   wire underrunEvt = txUnderrun && !eomLatch_r;

   // ==========================================================
   // crc initialise strobes
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rxCrcInit_r <= 1'b0;
         txCrcInit_r <= 1'b0;
         rxEnPrev_r  <= 1'b0;
      end else begin
         rxEnPrev_r  <= rxEnabled;
         // code 00 falls through every term below
         rxCrcInit_r <= (cmdWr && crcCode == `CRCRM_CRC_RXRST)
                     || (rxEnPrev_r && !rxEnabled)
                     || (sdlcMode && rxFrameEnd);
         // channel reset is absent here on purpose
         txCrcInit_r <= (cmdWr && crcCode == `CRCRM_CRC_TXRST)
                     || (autoEomReset && txFrameEnd);
      end
   end

   // ==========================================================
   // underrun/end_of_message latch and its underrun reaction
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         eomLatch_r  <= 1'b1;
         appendCrc_r <= 1'b0;
         sendAbort_r <= 1'b0;
      end else begin
         // start of crc wins over a reset issued in the same cycle
         if (crcTxStart)
            eomLatch_r <= 1'b1;
         else if (eomRstCmd && txEnabled)
            eomLatch_r <= 1'b0;
         appendCrc_r <= underrunEvt &&
                        !(sdlcMode && abortOnUnderrun);
         sendAbort_r <= underrunEvt && sdlcMode && abortOnUnderrun;
      end
   end

   // ==========================================================
   // external/status pending flag and latched underrun status bit
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         extPending_r <= 1'b0;
         eomStatus_r  <= 1'b1;
      end else begin
         if (extEvent || eomIdleEvt) begin
            extPending_r <= 1'b1;
            if (eomIdleEvt)
               eomStatus_r <= 1'b0;
            else
               eomStatus_r <= eomLatch_r;
         end else if ((cmdWr && extResetCmd) || chanReset) begin
            extPending_r <= 1'b0;
            eomStatus_r  <= eomLatch_r;
         end else if (!extPending_r) begin
            eomStatus_r  <= eomLatch_r;
         end
      end
   end

endmodule // crcrm_chan_ctl

/* dv/crcrm_regmap_asserts.sv */
// assertion checker for the crc command and register map block
`timescale 1ns/10ps
module crcrm_regmap_asserts #(
   parameter ADDR_W = 5
) (
   input wire              clock,
   input wire              arst_n,
   input wire [ADDR_W-1:0] addr,
   input wire [7:0]        wrData,
   input wire              wrStb,
   input wire              rdStb,
   input wire [7:0]        rdData_r,
   input wire [1:0]        txUnderrun,
   input wire [1:0]        crcTxStart,
   input wire [1:0]        txFrameEnd,
   input wire [1:0]        extEvent,
   input wire [1:0]        rxCrcInit_r,
   input wire [1:0]        txCrcInit_r,
   input wire [1:0]        appendCrc_r,
   input wire [1:0]        sendAbort_r,
   input wire [1:0]        eomLatch_r,
   input wire [1:0]        extPending_r
);
   wire chA     = addr[4];
   wire cmdW    = wrStb && addr[3:0] == 4'h0;
   wire txCmd   = cmdW && wrData[7:6] == 2'h2;
   wire rstCmdA = cmdW && chA && wrData[7:6] == 2'h3;
   wire anyEnd  = |txFrameEnd;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // command and event effects two cycles after their cause; hidden reads zero one cycle after the strobe
   rx_cmd_init_a: assert property (
      cmdW && wrData[7:6] == 2'h1 |-> ##2 rxCrcInit_r[$past(chA, 2)])
      else $error("rx init missing");
   tx_cmd_init_a: assert property (
      txCmd |-> ##2 txCrcInit_r[$past(chA, 2)])
      else $error("tx init missing");
   // null code and channel reset must never start the generator
   tx_init_cause_a: assert property (
      |txCrcInit_r |-> $past(txCmd, 2) || $past(anyEnd, 2))
      else $error("tx init without cause");
   latch_set_a: assert property (
      crcTxStart[1] |-> ##2 eomLatch_r[1])
      else $error("latch not set");
   latch_fall_a: assert property (
      $fell(eomLatch_r[1]) |-> $past(rstCmdA, 2))
      else $error("latch fell without reset");
   append_cause_a: assert property (
      appendCrc_r[1] |-> $past(txUnderrun[1], 2) && !$past(eomLatch_r[1], 1))
      else $error("append without cause");
   abort_cause_a: assert property (
      sendAbort_r[1] |-> $past(txUnderrun[1], 2) && !appendCrc_r[1])
      else $error("abort without underrun");
   ext_clear_a: assert property (
      cmdW && wrData[5:3] == 3'h2 && wrData[7:6] != 2'h3 && extEvent == 2'h0
      |-> ##2 !extPending_r[$past(chA, 2)])
      else $error("ext pending not cleared");
   ext_event_a: assert property (
      extEvent[1] |-> ##2 extPending_r[1])
      else $error("ext pending not set");
   rd_zero_a: assert property (
      rdStb && (addr[3:0] == 4'h1 || (!chA && addr[3:0] == 4'h3))
      |=> rdData_r == 8'h00)
      else $error("hidden read not zero");

   cover property (appendCrc_r[1]);
   cover property (sendAbort_r[1]);
   cover property ($fell(eomLatch_r[1]));
   cover property (extPending_r[0]);
endmodule // crcrm_regmap_asserts

bind crcrm_regmap crcrm_regmap_asserts #(.ADDR_W(ADDR_W)) chk (
   .clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData),
   .wrStb(wrStb), .rdStb(rdStb), .rdData_r(rdData_r),
   .txUnderrun(txUnderrun), .crcTxStart(crcTxStart),
   .txFrameEnd(txFrameEnd), .extEvent(extEvent),
   .rxCrcInit_r(rxCrcInit_r), .txCrcInit_r(txCrcInit_r),
   .appendCrc_r(appendCrc_r), .sendAbort_r(sendAbort_r),
   .eomLatch_r(eomLatch_r), .extPending_r(extPending_r));

/* dv/crcrm_host.sv */
// bus master model of the host processor
`timescale 1ns/10ps
module crcrm_host (
   input  wire       clock,
   input  wire [7:0] rdData_r,
   output reg  [4:0] addr,
   output reg  [7:0] wrData,
   output reg        wrStb,
   output reg        rdStb
);
   initial begin
      addr = 5'h00;
      wrData = 8'h00;
      wrStb = 1'b0;
      rdStb = 1'b0;
   end

   // callers pass reserved bits as zero and defined codes only
   task wr(input [4:0] a, input [7:0] dat);
      begin
         @(posedge clock);
         addr <= a;
         wrData <= dat;
         wrStb <= 1'b1;
         @(posedge clock);
         wrStb <= 1'b0;
      end
   endtask

   // data stands only in the cycle after the strobe
   task rd(input [4:0] a, output [7:0] dat);
      begin
         @(posedge clock);
         addr <= a;
         rdStb <= 1'b1;
         @(posedge clock);
         rdStb <= 1'b0;
         @(negedge clock);
         dat = rdData_r;
      end
   endtask
endmodule // crcrm_host

/* dv/crcrm_tb.sv */
// self-checking testbench for the crc command and register map block
`timescale 1ns/10ps
module testbench;
   reg          clock;
   reg          arst_n;
   reg  [9:0]   ev;
   reg  [15:0]  fcA;
   reg  [7:0]   d;
   wire [4:0]   addr;
   wire [7:0]   wrData;
   wire         wrStb;
   wire         rdStb;
   wire [7:0]   rdData_r;
   wire [1:0]   rxI;
   wire [1:0]   txI;
   wire [1:0]   apC;
   wire [1:0]   abT;
   wire [1:0]   latch;
   wire [1:0]   pend;
   wire [7:0]   pulses = {abT, apC, txI, rxI};
   integer      pc [0:7];
   integer      base [0:7];
   integer      n_mismatch;
   integer      checks;
   integer      i;
   integer      k;

   crcrm_host h (.clock(clock), .rdData_r(rdData_r), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb));
   crcrm_regmap #(.ADDR_W(5)) dut (.clock(clock), .arst_n(arst_n),
      .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
      .rdData_r(rdData_r), .txUnderrun(ev[9:8]), .crcTxStart(ev[7:6]),
      .txFrameEnd(ev[5:4]), .rxFrameEnd(ev[3:2]), .extEvent(ev[1:0]),
      .frameCountA(fcA), .frameCountB(16'h5678), .rxCrcInit_r(rxI),
      .txCrcInit_r(txI), .appendCrc_r(apC), .sendAbort_r(abT),
      .eomLatch_r(latch), .extPending_r(pend));

   initial clock = 1'b0;
   always #50 clock = ~clock;

   // pulses are counted so scenarios need not hit their exact cycle
   always @(posedge clock) begin
      for (k = 0; k < 8; k = k + 1)
         if (pulses[k] === 1'b1)
            pc[k] = pc[k] + 1;
   end

   // ==========================================================
   // helpers
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task snap;
      for (i = 0; i < 8; i = i + 1)
         base[i] = pc[i];
   endtask
   task settle;
      repeat (4) @(negedge clock);
   endtask
   task dlt(input string nm, input integer n, input [15:0] e);
      check(nm, pc[n] - base[n], e);
   endtask
   task rc(input [4:0] a, input [7:0] e, input string nm);
      begin
         h.rd(a, d);
         check(nm, d, e);
      end
   endtask
   task evp(input [9:0] m);
      begin
         @(posedge clock);
         ev <= m;
         @(posedge clock);
         ev <= 10'h000;
      end
   endtask

   // ==========================================================
   // scenarios
   task t_codes;
      integer c;
      begin
         for (c = 0; c < 2; c = c + 1) begin
            h.wr({c[0], 4'h5}, 8'h08);
            snap;
            h.wr({c[0], 4'h0}, 8'h00);
            settle;
            dlt("null rx", c, 0);
            dlt("null tx", 2 + c, 0);
            h.wr({c[0], 4'h0}, 8'h40);
            h.wr({c[0], 4'h0}, 8'h80);
            settle;
            dlt("rx init", c, 1);
            dlt("tx init", 2 + c, 1);
         end
         $display("codes test done");
      end
   endtask
   task t_reset;
      begin
         snap;
         h.wr(5'h03, 8'h01);
         h.wr(5'h03, 8'h00);
         settle;
         dlt("rx off", 0, 1);
         h.wr(5'h03, 8'h01);
         h.wr(5'h19, 8'h40);
         settle;
         dlt("chan rst rx", 0, 2);
         dlt("chan rst tx", 2, 0);
         $display("reset test done");
      end
   endtask
   task t_vector;
      begin
         h.wr(5'h02, 8'ha0);
         rc(5'h12, 8'ha0, "vector a");
         rc(5'h02, 8'ha6, "vector b idle");
         evp(10'h002);
         settle;
         rc(5'h02, 8'haa, "vector b ext");
         rc(5'h13, 8'h08, "pending a");
         rc(5'h03, 8'h00, "pending b");
         h.wr(5'h10, 8'h10);
         settle;
         check("ext clear a", pend[1], 0);
         $display("vector test done");
      end
   endtask
   task t_disabled;
      begin
         h.wr(5'h00, 8'hc0);
         settle;
         check("latch b", latch[0], 1);
         check("ext pend b", pend[0], 1);
         h.rd(5'h00, d);
         check("status eom", d[6], 0);
         h.wr(5'h00, 8'h10);
         settle;
         check("ext clear b", pend[0], 0);
         evp(10'h001);
         h.wr(5'h00, 8'hd0);
         settle;
         check("ext set wins", pend[0], 1);
         rc(5'h02, 8'ha2, "vector b extb");
         rc(5'h13, 8'h01, "pending extb");
         $display("disabled test done");
      end
   endtask
   task t_latch;
      begin
         snap;
         evp(10'h008);
         settle;
         dlt("rx no sdlc", 1, 0);
         h.wr(5'h10, 8'hc0);
         settle;
         check("latch reset", latch[1], 0);
         evp(10'h200);
         settle;
         dlt("append", 5, 1);
         evp(10'h080);
         settle;
         check("latch set", latch[1], 1);
         evp(10'h200);
         settle;
         dlt("no append", 5, 1);
         h.wr(5'h14, 8'h20);
         h.wr(5'h1a, 8'h04);
         h.wr(5'h10, 8'hc0);
         evp(10'h208);
         settle;
         dlt("abort", 7, 1);
         dlt("append sdlc", 5, 1);
         dlt("rx sdlc", 1, 1);
         $display("latch test done");
      end
   endtask
   task t_ext;
      begin
         snap;
         evp(10'h020);
         h.wr(5'h13, 8'h5a);
         rc(5'h19, 8'h00, "rx par hidden");
         rc(5'h16, 8'h00, "count hidden");
         h.wr(5'h1f, 8'h05);
         h.wr(5'h17, 8'h42);
         dlt("no auto eom", 3, 0);
         rc(5'h19, 8'h5a, "rx par rb");
         rc(5'h14, 8'h20, "mode rb");
         rc(5'h15, 8'h08, "tx par rb");
         rc(5'h1b, 8'h04, "misc rb");
         rc(5'h1e, 8'h42, "ext feat rb");
         rc(5'h16, 8'h34, "count lo");
         rc(5'h17, 8'h12, "count hi");
         rc(5'h06, 8'h00, "count b");
         rc(5'h11, 8'h00, "unmapped");
         h.wr(5'h1c, 8'h3c);
         rc(5'h1c, 8'h3c, "baud lo");
         h.wr(5'h1d, 8'hc3);
         rc(5'h1d, 8'hc3, "baud hi");
         evp(10'h020);
         settle;
         dlt("auto eom", 3, 1);
         // reset of both channels also clears the shared vector
         h.wr(5'h09, 8'hc0);
         settle;
         check("pend hw rst", pend, 0);
         rc(5'h12, 8'h00, "vector hw rst");
         $display("extended test done");
      end
   endtask

   // ==========================================================
   // verdict and main sequence
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      arst_n = 1'b0;
      ev = 10'h000;
      fcA = 16'h1234;
      n_mismatch = 0;
      checks = 0;
      for (i = 0; i < 8; i = i + 1)
         pc[i] = 0;
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      t_codes;
      t_reset;
      t_vector;
      t_disabled;
      t_latch;
      t_ext;
      print_verdict;
   end

   // the scenarios need well under two thousand cycles
   initial begin
      #2000000;
      n_mismatch = n_mismatch + 1;
      print_verdict;
   end
endmodule // testbench
